// ===== include/fm_pkg.sv
// Shared constants and carrier types of the trip fault manager
package fm_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int LOCK_FIRST_S = 2;
   localparam int LOCK_MAX_S = 64;
   localparam logic [2:0] LOCK_IDX_MAX = 3'h5;
   // Fault numbers, reported as binary values
   localparam logic [7:0] FC_NONE = 8'h00;
   localparam logic [7:0] FC_BRAKE_OC = 8'h01;
   localparam logic [7:0] FC_BRAKE_OL = 8'h02;
   localparam logic [7:0] FC_OUT_OC = 8'h03;
   localparam logic [7:0] FC_MOTOR_OL = 8'h04;
   localparam logic [7:0] FC_BUS_OV = 8'h06;
   localparam logic [7:0] FC_BUS_UV = 8'h07;
   localparam logic [7:0] FC_HS_OT = 8'h08;
   localparam logic [7:0] FC_UNDER_T = 8'h09;
   localparam logic [7:0] FC_EXT_TRIP = 8'h0B;
   localparam logic [7:0] FC_NET_LOSS = 8'h0C;
   localparam logic [7:0] FC_RIPPLE = 8'h0D;
   localparam logic [7:0] FC_PHASE_LOSS = 8'h0E;
   localparam logic [7:0] FC_HW_OC = 8'h0F;
   localparam logic [7:0] FC_IO_MEM = 8'h11;
   localparam logic [7:0] FC_ANALOG_LOST = 8'h12;
   localparam logic [7:0] FC_DSP_MEM = 8'h13;
   localparam logic [7:0] FC_MOTOR_PTC = 8'h15;
   localparam logic [7:0] FC_FAN = 8'h16;
   localparam logic [7:0] FC_INT_OT = 8'h17;
   localparam logic [7:0] FC_OUTPUT = 8'h1A;
   localparam logic [7:0] FC_AUTOTUNE = 8'h29;
   localparam logic [7:0] FC_MODBUS_LOSS = 8'h32;
   localparam logic [7:0] FC_CAN_LOSS = 8'h33;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_OL_REF = 8'h08;
   localparam logic [7:0] OFS_OL_LIMIT = 8'h0C;
   localparam logic [7:0] OFS_COMM_TO = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_LOCK_LEFT = 8'h1C;
   // Field positions
   localparam int CTRL_FB_RESET = 0;
   localparam int CTRL_MON_LSB = 1;
   localparam int ST_TRIPPED = 8;
   localparam int ST_LOCKED = 9;
   localparam int ST_IDX_LSB = 10;
   localparam int IRQ_TRIP = 0;
   localparam int IRQ_CLEAR = 1;
   // Reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [15:0] OL_REF_RST = 16'hFFFF;
   localparam logic [15:0] OL_LIMIT_RST = 16'h0000;
   localparam logic [15:0] COMM_TO_RST = 16'h0000;
   typedef enum logic {FM_READY, FM_TRIPPED} fm_state_t;
   typedef struct packed {
      logic brake_oc;
      logic brake_ol;
      logic out_oc;
      logic hardware_overcurrent_trip;
      logic bus_ov;
      logic bus_uv;
      logic hs_ot;
      logic under_temp;
      logic bus_ripple;
      logic phase_loss;
      logic io_mem;
      logic analog_lost;
      logic dsp_mem;
      logic motor_ptc;
      logic fan_fail;
      logic int_ot;
      logic output_fault;
      logic autotune_bad;
   } fm_cond_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } fm_wb_req_t;
endpackage : fm_pkg

// ===== rtl/fm_trip_manager.sv
// Drive trip supervision: fault latch, reset sources, lockout, registers
// Contract
// - Report 00 with no trip, 01 brake overcurrent, 02 brake resistor overload.
// - Trip 03 on instantaneous output overcurrent, 15 on short-circuit overcurrent.
// - Trip 04 when current above overload reference accumulates long enough.
// - Trip 06 on bus overvoltage, 07 on bus undervoltage.
// - Trip 08 heatsink hot, 09 too cold, 23 internal temperature high.
// - Trip 11 when the closed contact on digital input 3 opens.
// - Trip 12, 50, 51 when link traffic stops past the timeout.
// - Trip 13 on excessive bus ripple, 14 on input phase loss.
// - Report 17 IO memory fault, 19 DSP memory fault, 18 lost 4-20mA.
// - Trip 21 motor thermistor, 22 fan failure, 26 output fault.
// - Trip 41 when autotune motor parameters are wrong.
// - Clear trip on power cycle, enable re-assert, or stop key press.
// - Fieldbus clears a trip by a 0 to 1 control-word reset bit.
// - Overcurrent and overload trips ignore resets until lockout elapses; the code locks out only 03, 15 and 04, not 01 or 02.
// - Lockout is 2, 4, 8, 16, 32 s, then 64 s for later trips.
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module fm_trip_manager
   import fm_pkg::*;
#(
   parameter int MS_CYC = fm_pkg::MS_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire fm_pkg::fm_wb_req_t wb_req,
   output logic wb_ack,
   output logic [31:0] wb_dat_o,
   input wire fm_pkg::fm_cond_t cond,
   input wire logic din3_closed,
   input wire logic [15:0] out_current,
   input wire logic [2:0] link_traffic,
   input wire logic enable_in,
   input wire logic stop_key,
   input wire logic cw_reset_bit,
   output logic tripped,
   output logic [7:0] fault_code,
   output logic lockout_active,
   output logic irq
);
   import fm_pkg::*;

   // Highest hazard first when several conditions coincide
   function automatic logic [7:0] fm_pick(input fm_cond_t c, input logic ext,
                                          input logic ol, input logic [2:0] cl);
      logic [7:0] r;
      r = FC_NONE;
      if (c.brake_oc) r = FC_BRAKE_OC;
      else if (c.brake_ol) r = FC_BRAKE_OL;
      else if (c.hardware_overcurrent_trip) r = FC_HW_OC;
      else if (c.out_oc) r = FC_OUT_OC;
      else if (ol) r = FC_MOTOR_OL;
      else if (c.bus_ov) r = FC_BUS_OV;
      else if (c.bus_uv) r = FC_BUS_UV;
      else if (c.hs_ot) r = FC_HS_OT;
      else if (c.under_temp) r = FC_UNDER_T;
      else if (ext) r = FC_EXT_TRIP;
      else if (cl[0]) r = FC_NET_LOSS;
      else if (c.bus_ripple) r = FC_RIPPLE;
      else if (c.phase_loss) r = FC_PHASE_LOSS;
      else if (c.io_mem) r = FC_IO_MEM;
      else if (c.analog_lost) r = FC_ANALOG_LOST;
      else if (c.dsp_mem) r = FC_DSP_MEM;
      else if (c.motor_ptc) r = FC_MOTOR_PTC;
      else if (c.fan_fail) r = FC_FAN;
      else if (c.int_ot) r = FC_INT_OT;
      else if (c.output_fault) r = FC_OUTPUT;
      else if (c.autotune_bad) r = FC_AUTOTUNE;
      else if (cl[1]) r = FC_MODBUS_LOSS;
      else if (cl[2]) r = FC_CAN_LOSS;
      return r;
   endfunction : fm_pick

   function automatic logic [31:0] fm_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction : fm_merge

   fm_state_t state_reg;
   logic [31:0] ms_cnt_reg;
   logic [9:0] sec_ms_reg;
   logic [15:0] ol_acc_reg;
   logic [15:0] comm_cnt_reg [3];
   logic [6:0] lock_s_reg;
   logic [2:0] trip_idx_reg;
   logic en_prev_reg;
   logic stop_prev_reg;
   logic cw_prev_reg;
   logic [3:0] ctrl_reg;
   logic [15:0] ol_ref_reg;
   logic [15:0] ol_limit_reg;
   logic [15:0] comm_to_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;

   wire ms_tick = (ms_cnt_reg == 32'(MS_CYC - 1));
   wire sec_tick = ms_tick && (sec_ms_reg == 10'(MS_PER_S - 1));
   wire ol_trip = (ol_limit_reg != 16'h0000) && (ol_acc_reg >= ol_limit_reg);
   wire ext_trip = !din3_closed;
   wire [2:0] mon_en = ctrl_reg[CTRL_MON_LSB +: 3];
   wire [2:0] comm_loss;
   wire [7:0] code_w = fm_pick(cond, ext_trip, ol_trip, comm_loss);
   wire is_ready = (state_reg == FM_READY);
   wire new_trip = ce && is_ready && (code_w != FC_NONE);
   wire lock_code = (code_w == FC_OUT_OC) || (code_w == FC_HW_OC) ||
                    (code_w == FC_MOTOR_OL);
   wire [6:0] lock_delay = 7'(LOCK_FIRST_S) << trip_idx_reg;
   wire en_rise = enable_in && !en_prev_reg;
   wire stop_rise = stop_key && !stop_prev_reg;
   wire cw_rise = ctrl_reg[CTRL_FB_RESET] && cw_reset_bit && !cw_prev_reg;
   wire reset_req = en_rise || stop_rise || cw_rise;
   wire clear_ok = ce && !is_ready && reset_req && (lock_s_reg == 7'h00);
   wire wb_hit = wb_req.cyc && wb_req.stb && !wb_ack;
   wire wb_wr = ce && wb_hit && wb_req.we;
   wire [31:0] wb_wmask = fm_merge(32'h0000_0000, 32'hFFFF_FFFF, wb_req.sel);
   wire [1:0] w1c = (wb_wr && wb_req.adr == OFS_IRQ_STAT) ?
                    wb_wmask[1:0] & wb_req.dat[1:0] : 2'h0;
   wire [1:0] irq_ev = {clear_ok, new_trip};
   // A new event outranks a same-cycle clear from software
   wire [1:0] irq_stat_next = (irq_stat_reg & ~w1c) | irq_ev;
   wire [31:0] status_w = {19'h0, trip_idx_reg, lock_s_reg != 7'h00,
                           !is_ready, fault_code};
   logic [31:0] rd_w;
   // Write data laid over the addressed register's current value, byte lane by lane
   wire [31:0] wb_wdat = fm_merge(rd_w, wb_req.dat, wb_req.sel);

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_comm
         assign comm_loss[g] = mon_en[g] && (comm_cnt_reg[g] >= comm_to_reg);
         always_ff @(posedge mclk) begin
            if (reset || !mon_en[g] || (ce && link_traffic[g])) begin
               comm_cnt_reg[g] <= 16'h0000;
            end else if (ce && ms_tick && comm_cnt_reg[g] != 16'hFFFF) begin
               comm_cnt_reg[g] <= comm_cnt_reg[g] + 16'h0001;
            end
         end
      end
   endgenerate

   always_comb begin
      case (wb_req.adr)
         OFS_CTRL: rd_w = {28'h0, ctrl_reg};
         OFS_STATUS: rd_w = status_w;
         OFS_OL_REF: rd_w = {16'h0, ol_ref_reg};
         OFS_OL_LIMIT: rd_w = {16'h0, ol_limit_reg};
         OFS_COMM_TO: rd_w = {16'h0, comm_to_reg};
         OFS_IRQ_STAT: rd_w = {30'h0, irq_stat_reg};
         OFS_IRQ_MASK: rd_w = {30'h0, irq_mask_reg};
         OFS_LOCK_LEFT: rd_w = {25'h0, lock_s_reg};
         default: rd_w = 32'h0000_0000;
      endcase
   end

   // Bus slave: one wait state, unmapped addresses read zero and ignore writes
   always_ff @(posedge mclk) begin
      if (reset) begin
         wb_ack <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce) begin
         wb_ack <= wb_hit;
         wb_dat_o <= wb_hit ? rd_w : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_reg <= CTRL_RST;
         ol_ref_reg <= OL_REF_RST;
         ol_limit_reg <= OL_LIMIT_RST;
         comm_to_reg <= COMM_TO_RST;
         irq_mask_reg <= 2'h0;
      end else if (wb_wr) begin
         case (wb_req.adr)
            OFS_CTRL: ctrl_reg <= wb_wdat[3:0];
            OFS_OL_REF: ol_ref_reg <= wb_wdat[15:0];
            OFS_OL_LIMIT: ol_limit_reg <= wb_wdat[15:0];
            OFS_COMM_TO: comm_to_reg <= wb_wdat[15:0];
            OFS_IRQ_MASK: irq_mask_reg <= wb_wdat[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_stat_reg <= 2'h0;
         irq <= 1'b0;
      end else if (ce) begin
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ms_cnt_reg <= 32'h0000_0000;
         sec_ms_reg <= 10'h000;
      end else if (ce) begin
         ms_cnt_reg <= ms_tick ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
         if (ms_tick) begin
            sec_ms_reg <= sec_tick ? 10'h000 : sec_ms_reg + 10'h001;
         end
      end
   end

   // Overload integrator: counts ms above reference, bleeds off at or below it
   always_ff @(posedge mclk) begin
      if (reset) begin
         ol_acc_reg <= 16'h0000;
      end else if (ce && ms_tick) begin
         if (out_current > ol_ref_reg) begin
            if (ol_acc_reg != 16'hFFFF) ol_acc_reg <= ol_acc_reg + 16'h0001;
         end else if (ol_acc_reg != 16'h0000) begin
            ol_acc_reg <= ol_acc_reg - 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         // Enable idles high; a low start value would fake a rising edge
         en_prev_reg <= 1'b1;
         stop_prev_reg <= 1'b0;
         cw_prev_reg <= 1'b0;
      end else if (ce) begin
         en_prev_reg <= enable_in;
         stop_prev_reg <= stop_key;
         cw_prev_reg <= cw_reset_bit;
      end
   end

   // A power cycle is the reset itself, so it clears the trip and the count
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= FM_READY;
         fault_code <= FC_NONE;
         tripped <= 1'b0;
         lockout_active <= 1'b0;
         lock_s_reg <= 7'h00;
         trip_idx_reg <= 3'h0;
      end else if (ce) begin
         case (state_reg)
            FM_READY: begin
               if (new_trip) begin
                  state_reg <= FM_TRIPPED;
                  fault_code <= code_w;
                  tripped <= 1'b1;
                  if (lock_code) begin
                     lock_s_reg <= lock_delay;
                     lockout_active <= 1'b1;
                     if (trip_idx_reg != LOCK_IDX_MAX) begin
                        trip_idx_reg <= trip_idx_reg + 3'h1;
                     end
                  end
               end
            end
            FM_TRIPPED: begin
               if (clear_ok) begin
                  state_reg <= FM_READY;
                  fault_code <= FC_NONE;
                  tripped <= 1'b0;
               end else if (sec_tick && lock_s_reg != 7'h00) begin
                  lock_s_reg <= lock_s_reg - 7'h01;
                  lockout_active <= (lock_s_reg != 7'h01);
               end
            end
            default: state_reg <= FM_READY;
         endcase
      end
   end

   property p_brake_first;
      @(posedge mclk) disable iff (reset)
      ce && is_ready && cond.brake_oc |=> tripped && fault_code == FC_BRAKE_OC;
   endproperty
   a_brake_first: assert property (p_brake_first)
      else $error("brake overcurrent not reported as 01");

   property p_code_latch;
      @(posedge mclk) disable iff (reset)
      new_trip |=> fault_code == $past(code_w) && tripped;
   endproperty
   a_code_latch: assert property (p_code_latch)
      else $error("fault number not latched");

   property p_overload;
      @(posedge mclk) disable iff (reset)
      ce && is_ready && ol_trip && !(|cond[17:14]) |=> fault_code == FC_MOTOR_OL;
   endproperty
   a_overload: assert property (p_overload)
      else $error("overload did not raise 04");

   property p_lock_hold;
      @(posedge mclk) disable iff (reset)
      tripped && lock_s_reg != 7'h00 |=> tripped;
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("trip cleared during lockout");

   property p_lock_first;
      @(posedge mclk) disable iff (reset)
      new_trip && lock_code && trip_idx_reg == 3'h0 |=> lock_s_reg == 7'h02;
   endproperty
   a_lock_first: assert property (p_lock_first)
      else $error("first lockout is not 2 s");

   property p_lock_cap;
      @(posedge mclk) disable iff (reset)
      new_trip && lock_code && trip_idx_reg == LOCK_IDX_MAX |=> lock_s_reg == 7'h40;
   endproperty
   a_lock_cap: assert property (p_lock_cap)
      else $error("later lockout is not 64 s");

   property p_stop_clear;
      @(posedge mclk) disable iff (reset)
      ce && tripped && lock_s_reg == 7'h00 && stop_key && !$past(stop_key)
      && $past(ce) |=> !tripped;
   endproperty
   a_stop_clear: assert property (p_stop_clear)
      else $error("stop key did not clear trip");

   property p_cw_clear;
      @(posedge mclk) disable iff (reset)
      ce && tripped && lock_s_reg == 7'h00 && cw_rise |=> !tripped;
   endproperty
   a_cw_clear: assert property (p_cw_clear)
      else $error("control word reset ignored");

   property p_comm;
      @(posedge mclk) disable iff (reset)
      ce && is_ready && comm_loss[2] |=> tripped;
   endproperty
   a_comm: assert property (p_comm)
      else $error("CAN loss did not trip");

   property p_powerup;
      @(posedge mclk) disable iff (reset)
      $fell(reset) |-> trip_idx_reg == 3'h0 && !tripped;
   endproperty
   a_powerup: assert property (p_powerup)
      else $error("count not cleared at power-up");

   property p_ext_trip;
      @(posedge mclk) disable iff (reset)
      ce && is_ready && !din3_closed && !ol_trip && !(|cond[17:10])
      |=> fault_code == FC_EXT_TRIP;
   endproperty
   a_ext_trip: assert property (p_ext_trip)
      else $error("open contact did not raise 11");

   property p_undervolt;
      @(posedge mclk) disable iff (reset)
      ce && is_ready && cond.bus_uv && !ol_trip && !(|cond[17:13])
      |=> fault_code == FC_BUS_UV;
   endproperty
   a_undervolt: assert property (p_undervolt)
      else $error("bus undervoltage did not raise 07");

   property p_enable_clear;
      @(posedge mclk) disable iff (reset)
      ce && tripped && lock_s_reg == 7'h00 && en_rise |=> !tripped;
   endproperty
   a_enable_clear: assert property (p_enable_clear)
      else $error("enable reapplied did not clear trip");

   property p_lock_escalate;
      @(posedge mclk) disable iff (reset)
      new_trip && lock_code && trip_idx_reg != LOCK_IDX_MAX
      |=> trip_idx_reg == $past(trip_idx_reg) + 3'h1;
   endproperty
   a_lock_escalate: assert property (p_lock_escalate)
      else $error("lockout trip count did not advance");

endmodule : fm_trip_manager
`default_nettype wire

// ===== tb/fm_partner.sv
// Keypad, enable input and fieldbus master model facing the trip manager
`timescale 1ns/1ps
`default_nettype none
module fm_partner #(
   parameter int POLL_CYC = 8
) (
   input wire logic mclk,
   input wire logic [2:0] poll_en,
   output logic [2:0] link_traffic,
   output logic enable_in,
   output logic stop_key,
   output logic cw_reset_bit
);
   int poll_cnt = 0;
   initial begin
      link_traffic = 3'h0;
      enable_in = 1'b1;
      stop_key = 1'b0;
      cw_reset_bit = 1'b0;
   end
   // Cyclic traffic well inside the timeout while polling is on
   always @(posedge mclk) begin
      poll_cnt <= (poll_cnt == POLL_CYC - 1) ? 0 : poll_cnt + 1;
      link_traffic <= (poll_cnt == 0) ? poll_en : 3'h0;
   end
   // Kind 0 stop key, 1 enable removed then reapplied, 2 control-word bit raised
   task request(input int kind);
      @(posedge mclk);
      if (kind == 0) stop_key <= 1'b1;
      if (kind == 1) enable_in <= 1'b0;
      if (kind == 2) cw_reset_bit <= 1'b1;
      repeat (3) @(posedge mclk);
      stop_key <= 1'b0;
      enable_in <= 1'b1;
      cw_reset_bit <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : request
endmodule : fm_partner
`default_nettype wire

// ===== tb/fm_trip_manager_tb.sv
// Self-checking bench for the trip manager with keypad and fieldbus model
`timescale 1ns/1ps
`default_nettype none
module fm_trip_manager_tb;
   import fm_pkg::*;
   localparam int MS = 4;
   localparam int SEC = MS * 1000;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   fm_wb_req_t wb_req = '0;
   fm_cond_t cond = '0;
   logic din3_closed = 1'b1;
   logic [15:0] out_current = 16'h0000;
   logic [2:0] poll_en = 3'h7;
   logic wb_ack, tripped, lockout_active, irq, enable_in, stop_key, cw_reset_bit;
   logic [31:0] wb_dat_o, rd, v;
   logic [7:0] fault_code;
   logic [2:0] link_traffic;
   int fails = 0;
   int tests_run = 0;
   int lock_trips = 0;
   // Fault numbers of the condition fields, most significant field first
   int code_tab[18] = '{1, 2, 3, 15, 6, 7, 8, 9, 13, 14, 17, 18, 19, 21, 22, 23, 26, 41};
   int link_tab[3] = '{12, 50, 51};
   logic [7:0] ofs_tab[9] = '{OFS_CTRL, OFS_STATUS, OFS_OL_REF, OFS_OL_LIMIT, OFS_COMM_TO,
      OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_LOCK_LEFT, 8'h20};
   logic [31:0] rst_tab[9] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
   always #2 mclk = ~mclk;
   fm_trip_manager #(.MS_CYC(MS)) uut (.mclk(mclk), .reset(reset), .ce(ce), .wb_req(wb_req),
      .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .cond(cond), .din3_closed(din3_closed),
      .out_current(out_current), .link_traffic(link_traffic), .enable_in(enable_in),
      .stop_key(stop_key), .cw_reset_bit(cw_reset_bit), .tripped(tripped),
      .fault_code(fault_code), .lockout_active(lockout_active), .irq(irq));
   fm_partner #(.POLL_CYC(8)) u_partner (.mclk(mclk), .poll_en(poll_en),
      .link_traffic(link_traffic), .enable_in(enable_in), .stop_key(stop_key),
      .cw_reset_bit(cw_reset_bit));
   task give_verdict;
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task cycles(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : cycles
   // Ack and read data are taken at the rising edge that samples ack high,
   // before that edge's own register updates land
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack !== 1'b1);
      rd = wb_dat_o;
      wb_req <= '0;
      check("wb_latency", 32'(n), 32'h0000_0002);
   endtask : wb
   task expect_trip(input int code);
      cycles(3);
      check("fault_code", 32'(fault_code), 32'(code));
      check("tripped", 32'(tripped), 32'h0000_0001);
   endtask : expect_trip
   // Causes are removed and traffic resumed first, otherwise the trip returns at once
   task clear(input int kind);
      @(posedge mclk);
      cond <= '0;
      din3_closed <= 1'b1;
      out_current <= 16'h0000;
      poll_en <= 3'h7;
      repeat (12) @(posedge mclk);
      u_partner.request(kind);
      cycles(1);
      check("tripped", 32'(tripped), 32'h0000_0000);
      check("fault_code", 32'(fault_code), 32'h0000_0000);
   endtask : clear
   task lock_check(input int code);
      int s;
      s = 2 << ((lock_trips > 5) ? 5 : lock_trips);
      lock_trips++;
      wb(1'b0, OFS_LOCK_LEFT, 32'h0000_0000);
      check("lock_left", rd, (rd === 32'(s - 1)) ? 32'(s - 1) : 32'(s));
      wb(1'b0, OFS_STATUS, 32'h0000_0000);
      check("status", rd, 32'(((lock_trips > 5 ? 5 : lock_trips) << 10) | 32'h300 | code));
      @(posedge mclk);
      cond <= '0;
      out_current <= 16'h0000;
      u_partner.request(0);
      cycles((s - 1) * SEC - 200);
      check("tripped", 32'(tripped), 32'h0000_0001);
      check("lockout_active", 32'(lockout_active), 32'h0000_0001);
      cycles(SEC + 400);
      check("lockout_active", 32'(lockout_active), 32'h0000_0000);
      clear(1);
   endtask : lock_check
   initial begin
      repeat (60000) @(posedge mclk);
      fails++;
      $display("unexpected watchdog: expected done, seen timeout");
      give_verdict();
   end
   initial begin
      void'($urandom(59817));
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         wb(1'b0, ofs_tab[i], 32'h0000_0000);
         check("reg_reset", rd, rst_tab[i]);
      end
      v = $urandom;
      for (int i = 1; i < 9; i += 7) begin
         wb(1'b1, ofs_tab[i], v);
         wb(1'b0, ofs_tab[i], 32'h0000_0000);
         check("ro_write", rd, 32'h0000_0000);
      end
      wb(1'b1, OFS_OL_REF, v);
      wb(1'b0, OFS_OL_REF, 32'h0000_0000);
      check("ol_ref", rd, {16'h0000, v[15:0]});
      wb(1'b1, OFS_CTRL, 32'h0000_0001);
      wb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      @(posedge mclk);
      cond.brake_oc <= 1'b1;
      expect_trip(1);
      check("irq", 32'(irq), 32'h0000_0001);
      wb(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
      cycles(2);
      check("irq", 32'(irq), 32'h0000_0000);
      // A key press while the clock enable is low must go unseen
      @(posedge mclk);
      ce <= 1'b0;
      u_partner.request(0);
      ce <= 1'b1;
      cycles(2);
      check("tripped", 32'(tripped), 32'h0000_0001);
      clear(0);
      wb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
      check("irq_stat", rd, 32'h0000_0002);
      wb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
      cycles(2);
      check("irq", 32'(irq), 32'h0000_0001);
      wb(1'b1, OFS_IRQ_STAT, 32'h0000_0003);
      wb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
      for (int i = 0; i < 18; i++) begin
         if (code_tab[i] == 3 || code_tab[i] == 15) continue;
         @(posedge mclk);
         cond[17 - i] <= 1'b1;
         expect_trip(code_tab[i]);
         clear(i % 3);
      end
      wb(1'b1, OFS_CTRL, 32'h0000_0000);
      @(posedge mclk);
      cond.bus_uv <= 1'b1;
      expect_trip(7);
      // Cause removed first, so only the gated control word could clear the trip
      @(posedge mclk);
      cond <= '0;
      u_partner.request(2);
      cycles(1);
      check("tripped", 32'(tripped), 32'h0000_0001);
      wb(1'b1, OFS_CTRL, 32'h0000_0001);
      clear(2);
      @(posedge mclk);
      din3_closed <= 1'b0;
      expect_trip(11);
      clear(1);
      wb(1'b1, OFS_COMM_TO, 32'h0000_0005);
      wb(1'b1, OFS_CTRL, 32'h0000_000F);
      cycles(40);
      check("tripped", 32'(tripped), 32'h0000_0000);
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk);
         poll_en <= 3'h7 & ~(3'h1 << k);
         cycles(40);
         expect_trip(link_tab[k]);
         clear(0);
      end
      wb(1'b1, OFS_CTRL, 32'h0000_0001);
      @(posedge mclk);
      cond.out_oc <= 1'b1;
      expect_trip(3);
      lock_check(3);
      wb(1'b1, OFS_OL_REF, 32'h0000_0064);
      wb(1'b1, OFS_OL_LIMIT, 32'h0000_0003);
      @(posedge mclk);
      out_current <= 16'h0064;
      cycles(40);
      check("tripped", 32'(tripped), 32'h0000_0000);
      @(posedge mclk);
      out_current <= 16'h00C8;
      cycles(6);
      check("tripped", 32'(tripped), 32'h0000_0000);
      cycles(20);
      expect_trip(4);
      lock_check(4);
      @(posedge mclk);
      reset <= 1'b1;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      lock_trips = 0;
      @(posedge mclk);
      cond.hardware_overcurrent_trip <= 1'b1;
      expect_trip(15);
      lock_check(15);
      give_verdict();
   end
endmodule : fm_trip_manager_tb
`default_nettype wire
